/* logic/ppw_defs.svh */
`ifndef PPW_DEFS_SVH
`define PPW_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Block decode: high address byte of the register window.
`define PPW_BASE_HI     8'h80

// Word register indices; byte address = base + 2 * index + byte select.
`define PPW_R_CTRL      5'h00
`define PPW_R_PLANE     5'h01
`define PPW_R_FG        5'h02
`define PPW_R_BG        5'h03
`define PPW_R_WX0       5'h04
`define PPW_R_WY0       5'h05
`define PPW_R_WX1       5'h06
`define PPW_R_WY1       5'h07
`define PPW_R_CURX      5'h08
`define PPW_R_CURY      5'h09
`define PPW_R_TEXT      5'h0A
`define PPW_R_RASTER    5'h0B
`define PPW_R_IMAGE     5'h0C
`define PPW_R_ENDX      5'h0D
`define PPW_R_VECY      5'h0E
`define PPW_R_PLOTY     5'h0F
`define PPW_R_READ      5'h10
`define PPW_R_RDATA     5'h11
`define PPW_R_STATUS    5'h12
`define PPW_R_FIDX      5'h13
`define PPW_R_FDATA     5'h14
`define PPW_R_IRQ       5'h15
`define PPW_R_DMA       5'h16

////////////////////////////////////////////////////////////////////////////////
// Control word fields.
`define PPW_C_REV       0
`define PPW_C_ADD       1
`define PPW_C_Y512      2
`define PPW_C_X640      3
`define PPW_C_SCAN      5:4
`define PPW_CTRL_RST    6'h00
`define PPW_FG_RST      16'h0FFF
`define PPW_BG_RST      16'h0000
`define PPW_PLANE_RST   16'h0FFF
`define PPW_WX1_RST     10'h27F
`define PPW_WY1_RST     10'h1FF

////////////////////////////////////////////////////////////////////////////////
// Character codes, cell and glyph geometry.
`define PPW_CODE_MIN    8'h20
`define PPW_CODE_MAX    8'h5F
`define PPW_CELL_W      4'h7
`define PPW_CELL_H      4'h9
`define PPW_COL_LAST    3'h6
`define PPW_ROW_LAST    4'h8
`define PPW_GLY_COL_MAX 3'h5
`define PPW_GLY_ROW_MAX 4'h7

// Element address folding for narrow and wide element systems.
`define PPW_XN_LIM      10'h140
`define PPW_XN_EDGE     10'h13E
`define PPW_XW_LIM      10'h280
`define PPW_XW_EDGE     10'h27C

`endif

/* logic/ppw_pkg.sv */
package ppw_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_TEXT,
		ST_RASTER,
		ST_IMAGE,
		ST_LINE,
		ST_BAR,
		ST_READ
	} ppw_state_t;

endpackage : ppw_pkg

/* logic/ppw_font_store.sv */
module ppw_font_store #(
	parameter int GLYPHS = 64,
	parameter int ROWS   = 7,
	parameter int COLS   = 5
) (
	// Clock and reset
	input  wire logic            i_mclk,
	input  wire logic            i_rst,
	// Pattern load port
	input  wire logic            i_we,
	input  wire logic [5:0]      i_wglyph,
	input  wire logic [2:0]      i_wrow,
	input  wire logic [COLS-1:0] i_wbits,
	// Pattern lookup port
	input  wire logic [5:0]      i_rglyph,
	input  wire logic [2:0]      i_rrow,
	output logic      [COLS-1:0] o_rbits
);

	if (GLYPHS != 64 || ROWS != 7 || COLS != 5)
		$error("ppw_font_store: only a 64 x 7 x 5 store is supported");

	logic [COLS-1:0] mem [GLYPHS*ROWS];

	function automatic logic [8:0] slot(input logic [5:0] g,
		input logic [2:0] r);
		logic [8:0] s;
		s = 9'({g, 3'h0}) - 9'({3'h0, g}) + 9'({6'h0, r});
		return s;
	endfunction : slot

	// Rows beyond the glyph height still read here; the caller masks the result.
	assign o_rbits = mem[slot(i_rglyph, i_rrow)];

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < GLYPHS*ROWS; i++)
				mem[i] <= '0;
		end else if (i_we && i_wrow < 3'(ROWS)) begin
			mem[slot(i_wglyph, i_wrow)] <= i_wbits;
		end
	end

endmodule : ppw_font_store

/* logic/ppw_pattern_writer.sv */
// Notes on behaviour
// - Text word splits into two 8-bit codes, high byte first, each one glyph.
// - Glyph is 5 wide by 7 high inside a 7 by 9 cell.
// - Only codes 20 to 5F hex draw; others are skipped.
// - Foreground value for one bits, background value for zero bits.
// - Reverse-background swaps which value ones and zeros take.
// - Additive mode writes only pixels whose pattern bit is one.
// - Text pixels outside the window rectangle are not written.
// - Scan setting sets character advance direction and margin step.
// - Raster byte gives eight pixels, one per bit, same value mapping.
// - Raster pixels are clipped to window; scan sets step and margin step.
// - Lines run from the retained endpoint to the new endpoint.
// - Bar plot fills rectangle between retained plot point and new endpoint.
// - Line and bar writes ignore the window.
// - Registers decode at processor addresses 8000 to 803F hex.
// - Registers set planes, patterns, address, transfer starts, host requests.
// - One pixel at a time can be read back from refresh memory.
// - Four host requests, each passed only while its host enable is set.
// - Byte-wide processor writes are paired into 16-bit internal words.
// - Image word writes one pixel using its low 12 bits.
// - Line address wraps modulo 256 or 512 by line resolution.
// - Overrange elements fold to 318/319 or 636..639 by low address bits.
`include "ppw_defs.svh"

module ppw_pattern_writer #(
	parameter int PIX_W = 12
) (
	// Clock and reset
	input  wire logic             i_mclk,
	input  wire logic             i_rst,
	// Processor register port
	input  wire logic [15:0]      i_addr,
	input  wire logic [7:0]       i_wdata,
	input  wire logic             i_wr,
	input  wire logic             i_rd,
	output logic      [7:0]       o_rdata,
	// Refresh memory
	output logic                  o_mem_we,
	output logic                  o_mem_re,
	output logic      [9:0]       o_mem_x,
	output logic      [8:0]       o_mem_y,
	output logic      [PIX_W-1:0] o_mem_data,
	output logic      [PIX_W-1:0] o_mem_planes,
	input  wire logic [PIX_W-1:0] i_mem_rdata,
	input  wire logic             i_mem_rvalid,
	// Host interface
	input  wire logic [3:0]       i_irq_en,
	output logic      [3:0]       o_host_irq,
	output logic                  o_dma_start,
	output logic      [1:0]       o_dma_kind
);

	if (PIX_W != 12)
		$error("ppw_pattern_writer: pixel width must be 12");

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	function automatic logic wsel(input logic c, input logic [4:0] i,
		input logic [4:0] r);
		return c && (i == r);
	endfunction : wsel

	function automatic logic [9:0] map_x(input logic [9:0] x,
		input logic wide);
		if (!wide && x >= `PPW_XN_LIM)
			return `PPW_XN_EDGE | {9'h000, x[0]};
		if (wide && x >= `PPW_XW_LIM)
			return `PPW_XW_EDGE | {8'h00, x[1:0]};
		return x;
	endfunction : map_x

	function automatic logic [8:0] map_y(input logic [9:0] y,
		input logic tall);
		return {y[8] & tall, y[7:0]};
	endfunction : map_y

	// Step along one axis inside [lo, hi]; bit 10 flags a margin wrap.
	function automatic logic [10:0] adv(input logic [9:0] p,
		input logic [9:0] lo, input logic [9:0] hi,
		input logic [3:0] s, input logic back);
		logic [10:0] n;
		n = back ? 11'({1'b0, p}) - 11'({7'h00, s})
			: 11'({1'b0, p}) + 11'({7'h00, s});
		if (!back && (n > {1'b0, hi} || n[10]))
			return {1'b1, lo};
		if (back && (n[10] || n[9:0] < lo))
			return {1'b1, 10'(11'({1'b0, hi}) + 11'h001 - 11'({7'h00, s}))};
		return {1'b0, n[9:0]};
	endfunction : adv

	function automatic logic signed [11:0] mag(input logic signed [11:0] v);
		return v[11] ? -v : v;
	endfunction : mag

	////////////////////////////////////////////////////////////////////////
	// Register port decode.

	logic [7:0]       lo_hold;
	logic [5:0]       ctrl;
	logic [PIX_W-1:0] plane;
	logic [PIX_W-1:0] fg;
	logic [PIX_W-1:0] bg;
	logic [9:0]       wx0, wy0, wx1, wy1, end_x;
	logic [8:0]       fidx;
	logic [3:0]       irq_req;
	logic [3:0]       en_s1, en_s2, en_s3, en_q;
	ppw_pkg::ppw_state_t st;
	logic [9:0]       cur_x, cur_y, vx, vy, pxp, pyp;
	logic [15:0]      txt;
	logic             chsel;
	logic [2:0]       col, bitn;
	logic [3:0]       row;
	logic [7:0]       rbyte;
	logic [PIX_W-1:0] img, rd_data;
	logic signed [11:0] lx, ly, ex, ey, dx, dy, err;
	logic             sx, sy, rd_wait, rd_ok;
	logic [15:0]      rword;

	wire        blk    = i_addr[15:8] == `PPW_BASE_HI;
	wire        mapped = blk && i_addr[7:6] == 2'b00;
	wire [4:0]  widx   = i_addr[5:1];
	wire        commit = i_wr && mapped && i_addr[0];
	wire [15:0] wword  = {i_wdata, lo_hold};
	wire        idle   = st == ppw_pkg::ST_IDLE;

	wire w_ctrl  = wsel(commit, widx, `PPW_R_CTRL);
	wire w_text  = wsel(commit, widx, `PPW_R_TEXT);
	wire w_rast  = wsel(commit, widx, `PPW_R_RASTER);
	wire w_img   = wsel(commit, widx, `PPW_R_IMAGE);
	wire w_vec   = wsel(commit, widx, `PPW_R_VECY);
	wire w_plot  = wsel(commit, widx, `PPW_R_PLOTY);
	wire w_read  = wsel(commit, widx, `PPW_R_READ);
	wire w_curx  = wsel(commit, widx, `PPW_R_CURX);
	wire w_cury  = wsel(commit, widx, `PPW_R_CURY);
	wire w_fdata = wsel(commit, widx, `PPW_R_FDATA);
	wire w_irq   = wsel(commit, widx, `PPW_R_IRQ);
	wire w_dma   = wsel(commit, widx, `PPW_R_DMA);
	wire r_rdata = wsel(i_rd && mapped, widx, `PPW_R_RDATA);

	wire rev  = ctrl[`PPW_C_REV];
	wire add  = ctrl[`PPW_C_ADD];
	wire y512 = ctrl[`PPW_C_Y512];
	wire x640 = ctrl[`PPW_C_X640];
	wire [1:0] scan = ctrl[`PPW_C_SCAN];

	////////////////////////////////////////////////////////////////////////
	// Pattern sources.

	wire [7:0] code    = chsel ? txt[7:0] : txt[15:8];
	wire       code_ok = code >= `PPW_CODE_MIN && code <= `PPW_CODE_MAX;
	wire [7:0] gl8     = code - `PPW_CODE_MIN;
	wire [3:0] r1      = row - 4'h1;
	wire [2:0] bsel    = `PPW_GLY_COL_MAX - col;
	wire [4:0] fbits;
	wire in_gl = col != 3'h0 && col <= `PPW_GLY_COL_MAX
		&& row != 4'h0 && row <= `PPW_GLY_ROW_MAX;
	wire gbit  = in_gl && fbits[bsel];

	ppw_font_store #(
		.GLYPHS (64),
		.ROWS   (7),
		.COLS   (5)
	) u_font (
		.i_mclk   (i_mclk),
		.i_rst    (i_rst),
		.i_we     (w_fdata),
		.i_wglyph (fidx[8:3]),
		.i_wrow   (fidx[2:0]),
		.i_wbits  (wword[4:0]),
		.i_rglyph (gl8[5:0]),
		.i_rrow   (r1[2:0]),
		.o_rbits  (fbits)
	);

	wire in_text = st == ppw_pkg::ST_TEXT;
	wire in_rast = st == ppw_pkg::ST_RASTER;
	wire in_img  = st == ppw_pkg::ST_IMAGE;
	wire in_gfx  = st == ppw_pkg::ST_LINE || st == ppw_pkg::ST_BAR;
	wire in_read = st == ppw_pkg::ST_READ;

	wire pbit = in_text ? gbit : in_rast ? rbyte[bitn] : 1'b1;
	wire use_fg = pbit ^ rev;
	wire p_en   = !add || pbit;
	wire [PIX_W-1:0] pval = in_img ? img : use_fg ? fg : bg;

	wire [9:0] px = in_text ? cur_x + 10'({7'h00, col})
		: in_gfx ? lx[9:0] : cur_x;
	wire [9:0] py = in_text ? cur_y + 10'({6'h00, row})
		: in_gfx ? ly[9:0] : cur_y;
	wire in_win = px >= wx0 && px <= wx1 && py >= wy0 && py <= wy1;
	wire draw = (in_text && code_ok) || in_rast || in_img || in_gfx;
	wire pix_we = draw && p_en && (in_gfx || in_win);
	wire pix_re = in_read && !rd_wait;

	////////////////////////////////////////////////////////////////////////
	// Cursor stepping; text steps a whole cell, raster, image and read one pixel; line and bar leave the cursor.

	wire        x_prim = !scan[0];
	wire [3:0]  stp_x  = in_text ? `PPW_CELL_W : 4'h1;
	wire [3:0]  stp_y  = in_text ? `PPW_CELL_H : 4'h1;
	wire [10:0] ax = adv(cur_x, wx0, wx1, stp_x, scan[1] && x_prim);
	wire [10:0] ay = adv(cur_y, wy0, wy1, stp_y, scan[1] && !x_prim);
	wire [9:0]  next_cx = x_prim ? ax[9:0] : (ay[10] ? ax[9:0] : cur_x);
	wire [9:0]  next_cy = x_prim ? (ax[10] ? ay[9:0] : cur_y) : ay[9:0];

	wire cell_end = col == `PPW_COL_LAST && row == `PPW_ROW_LAST;
	wire step = (in_text && code_ok && cell_end) || in_rast || in_img
		|| (in_read && i_mem_rvalid);

	////////////////////////////////////////////////////////////////////////
	// Line and bar set-up.

	wire signed [11:0] nx  = {2'b00, end_x};
	wire signed [11:0] ny  = {2'b00, wword[9:0]};
	wire signed [11:0] vdx = nx - {2'b00, vx};
	wire signed [11:0] vdy = ny - {2'b00, vy};
	wire signed [11:0] e2  = err <<< 1;
	wire g_x   = e2 >= dy;
	wire g_y   = e2 <= dx;
	wire l_end = lx == ex && ly == ey;
	wire b_xe  = lx == ex;
	wire b_end = b_xe && ly == ey;
	wire [9:0] bx0 = end_x < pxp ? end_x : pxp;
	wire [9:0] bx1 = end_x < pxp ? pxp : end_x;
	wire [9:0] by0 = wword[9:0] < pyp ? wword[9:0] : pyp;
	wire [9:0] by1 = wword[9:0] < pyp ? pyp : wword[9:0];

	////////////////////////////////////////////////////////////////////////
	// Configuration registers.

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			lo_hold <= 8'h00;
			ctrl    <= `PPW_CTRL_RST;
			plane   <= PIX_W'(`PPW_PLANE_RST);
			fg      <= PIX_W'(`PPW_FG_RST);
			bg      <= PIX_W'(`PPW_BG_RST);
			wx0     <= 10'h000;
			wy0     <= 10'h000;
			wx1     <= `PPW_WX1_RST;
			wy1     <= `PPW_WY1_RST;
			end_x   <= 10'h000;
			fidx    <= 9'h000;
		end else begin
			if (i_wr && mapped && !i_addr[0])
				lo_hold <= i_wdata;
			if (w_ctrl)
				ctrl <= wword[5:0];
			if (wsel(commit, widx, `PPW_R_PLANE))
				plane <= wword[PIX_W-1:0];
			if (wsel(commit, widx, `PPW_R_FG))
				fg <= wword[PIX_W-1:0];
			if (wsel(commit, widx, `PPW_R_BG))
				bg <= wword[PIX_W-1:0];
			if (wsel(commit, widx, `PPW_R_WX0))
				wx0 <= wword[9:0];
			if (wsel(commit, widx, `PPW_R_WY0))
				wy0 <= wword[9:0];
			if (wsel(commit, widx, `PPW_R_WX1))
				wx1 <= wword[9:0];
			if (wsel(commit, widx, `PPW_R_WY1))
				wy1 <= wword[9:0];
			if (wsel(commit, widx, `PPW_R_ENDX))
				end_x <= wword[9:0];
			if (wsel(commit, widx, `PPW_R_FIDX))
				fidx <= wword[8:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Host requests and transfer starts.

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			en_s1       <= 4'h0;
			en_s2       <= 4'h0;
			en_s3       <= 4'h0;
			en_q        <= 4'h0;
			irq_req     <= 4'h0;
			o_host_irq  <= 4'h0;
			o_dma_start <= 1'b0;
			o_dma_kind  <= 2'h0;
		end else begin
			en_s1 <= i_irq_en;
			en_s2 <= en_s1;
			en_s3 <= en_s2;
			en_q  <= (en_s2 & en_s3) | (en_q & (en_s2 | en_s3));
			// A set in the same word as a clear leaves the request set.
			if (w_irq)
				irq_req <= (irq_req & ~wword[7:4]) | wword[3:0];
			o_host_irq  <= irq_req & en_q;
			o_dma_start <= w_dma;
			if (w_dma)
				o_dma_kind <= wword[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Drawing engine.

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			st <= ppw_pkg::ST_IDLE;
			{cur_x, cur_y, vx, vy, pxp, pyp} <= '0;
			{txt, chsel, col, row, rbyte, bitn, img} <= '0;
			{lx, ly, ex, ey, dx, dy, err, sx, sy} <= '0;
			{rd_wait, rd_data, rd_ok} <= '0;
		end else begin
			rd_ok <= (in_read && i_mem_rvalid) || (rd_ok && !r_rdata);
			if (step) begin
				cur_x <= next_cx;
				cur_y <= next_cy;
			end
			case (st)
			ppw_pkg::ST_IDLE: begin
				if (w_curx)
					cur_x <= wword[9:0];
				if (w_cury)
					cur_y <= wword[9:0];
				if (w_text) begin
					st    <= ppw_pkg::ST_TEXT;
					txt   <= wword;
					chsel <= 1'b0;
					col   <= 3'h0;
					row   <= 4'h0;
				end else if (w_rast) begin
					st    <= ppw_pkg::ST_RASTER;
					rbyte <= wword[7:0];
					bitn  <= 3'h7;
				end else if (w_img) begin
					st  <= ppw_pkg::ST_IMAGE;
					img <= wword[PIX_W-1:0];
				end else if (w_vec) begin
					st  <= ppw_pkg::ST_LINE;
					lx  <= {2'b00, vx};
					ly  <= {2'b00, vy};
					ex  <= nx;
					ey  <= ny;
					dx  <= mag(vdx);
					dy  <= -mag(vdy);
					err <= mag(vdx) - mag(vdy);
					sx  <= vdx[11];
					sy  <= vdy[11];
					vx  <= end_x;
					vy  <= wword[9:0];
				end else if (w_plot) begin
					st  <= ppw_pkg::ST_BAR;
					lx  <= {2'b00, bx0};
					ly  <= {2'b00, by0};
					dx  <= {2'b00, bx0};
					ex  <= {2'b00, bx1};
					ey  <= {2'b00, by1};
					pxp <= end_x;
					pyp <= wword[9:0];
				end else if (w_read) begin
					st      <= ppw_pkg::ST_READ;
					rd_wait <= 1'b0;
				end
			end
			ppw_pkg::ST_TEXT: begin
				if (!code_ok || cell_end) begin
					col   <= 3'h0;
					row   <= 4'h0;
					chsel <= 1'b1;
					if (chsel)
						st <= ppw_pkg::ST_IDLE;
				end else if (col == `PPW_COL_LAST) begin
					col <= 3'h0;
					row <= row + 4'h1;
				end else begin
					col <= col + 3'h1;
				end
			end
			ppw_pkg::ST_RASTER: begin
				bitn <= bitn - 3'h1;
				if (bitn == 3'h0)
					st <= ppw_pkg::ST_IDLE;
			end
			ppw_pkg::ST_IMAGE:
				st <= ppw_pkg::ST_IDLE;
			ppw_pkg::ST_LINE: begin
				if (l_end) begin
					st <= ppw_pkg::ST_IDLE;
				end else begin
					if (g_x && g_y)
						err <= err + dy + dx;
					else if (g_x)
						err <= err + dy;
					else if (g_y)
						err <= err + dx;
					if (g_x)
						lx <= sx ? lx - 12'sh001 : lx + 12'sh001;
					if (g_y)
						ly <= sy ? ly - 12'sh001 : ly + 12'sh001;
				end
			end
			ppw_pkg::ST_BAR: begin
				if (b_end) begin
					st <= ppw_pkg::ST_IDLE;
				end else if (b_xe) begin
					lx <= dx;
					ly <= ly + 12'sh001;
				end else begin
					lx <= lx + 12'sh001;
				end
			end
			ppw_pkg::ST_READ: begin
				rd_wait <= 1'b1;
				if (i_mem_rvalid) begin
					rd_data <= i_mem_rdata;
					st      <= ppw_pkg::ST_IDLE;
				end
			end
			default:
				st <= ppw_pkg::ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read-back selection and registered outputs.

	always_comb begin
		case (widx)
		`PPW_R_CTRL:   rword = {10'h000, ctrl};
		`PPW_R_PLANE:  rword = 16'(plane);
		`PPW_R_FG:     rword = 16'(fg);
		`PPW_R_BG:     rword = 16'(bg);
		`PPW_R_WX0:    rword = {6'h00, wx0};
		`PPW_R_WY0:    rword = {6'h00, wy0};
		`PPW_R_WX1:    rword = {6'h00, wx1};
		`PPW_R_WY1:    rword = {6'h00, wy1};
		`PPW_R_CURX:   rword = {6'h00, cur_x};
		`PPW_R_CURY:   rword = {6'h00, cur_y};
		`PPW_R_ENDX:   rword = {6'h00, end_x};
		`PPW_R_RDATA:  rword = 16'(rd_data);
		`PPW_R_STATUS: rword = {8'h00, !idle, rd_ok, 2'h0, en_q};
		`PPW_R_FIDX:   rword = {7'h00, fidx};
		`PPW_R_IRQ:    rword = {12'h000, irq_req};
		default:       rword = 16'h0000;
		endcase
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata      <= 8'h00;
			o_mem_we     <= 1'b0;
			o_mem_re     <= 1'b0;
			o_mem_x      <= 10'h000;
			o_mem_y      <= 9'h000;
			o_mem_data   <= '0;
			o_mem_planes <= '0;
		end else begin
			o_rdata <= !(i_rd && mapped) ? 8'h00
				: i_addr[0] ? rword[15:8] : rword[7:0];
			o_mem_we     <= pix_we;
			o_mem_re     <= pix_re;
			o_mem_x      <= map_x(px, x640);
			o_mem_y      <= map_y(py, y512);
			o_mem_data   <= pval;
			o_mem_planes <= plane;
		end
	end

endmodule : ppw_pattern_writer

/* test/ppw_pattern_writer_asserts.sv */
module ppw_pattern_writer_asserts (
	// Clock and reset
	input wire logic        i_mclk,
	input wire logic        i_rst,
	// Register port
	input wire logic [15:0] i_addr,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [7:0]  o_rdata,
	// Memory and host
	input wire logic        o_mem_we,
	input wire logic        o_mem_re,
	input wire logic [9:0]  o_mem_x,
	input wire logic [3:0]  i_irq_en,
	input wire logic [3:0]  o_host_irq,
	input wire logic        o_dma_start
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);
////////////////////////////////////////////////////////////////////////////////
	chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside the answer cycle");
	chk_decode_out: assert property (
		i_rd && i_addr[15:8] != 8'h80 |=> o_rdata == 8'h00)
		else $error("foreign address answered");
	chk_reserved_zero: assert property (
		i_rd && i_addr[15:6] == 10'h203 |=> o_rdata == 8'h00)
		else $error("reserved address answered");
	// The enable crosses a synchroniser, so a window of three lags is allowed.
	chk_irq_gated: assert property ((o_host_irq & ~($past(i_irq_en, 3) |
		$past(i_irq_en, 4) | $past(i_irq_en, 5))) == 4'h0)
		else $error("host request without enable");
	chk_we_re_excl: assert property (!(o_mem_we && o_mem_re))
		else $error("write and read together");
	chk_read_pulse: assert property (o_mem_re |=> !o_mem_re)
		else $error("read request too long");
	chk_dma_cause: assert property (o_dma_start |->
		$past(i_wr) && $past(i_addr) == 16'h802D)
		else $error("transfer start without write");
	chk_x_fold: assert property (o_mem_we |-> o_mem_x <= 10'h27F)
		else $error("element address beyond range");
	chk_mem_quiet: assert property (
		$past(i_rst) |-> !o_mem_we && o_host_irq == 4'h0)
		else $error("activity right after reset");
	cover property (o_mem_we);
	cover property (o_mem_re);
	cover property (o_dma_start);
	cover property (o_host_irq != 4'h0);
endmodule : ppw_pattern_writer_asserts

bind ppw_pattern_writer ppw_pattern_writer_asserts u_chk (
	.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .o_mem_we(o_mem_we),
	.o_mem_re(o_mem_re), .o_mem_x(o_mem_x), .i_irq_en(i_irq_en),
	.o_host_irq(o_host_irq), .o_dma_start(o_dma_start)
);

/* test/ppw_mem_model.sv */
module ppw_mem_model #(
	parameter int W   = 12,
	parameter int LAT = 3
) (
	// Clock and reset
	input  wire logic         i_mclk,
	input  wire logic         i_rst,
	// Pixel port
	input  wire logic         i_we,
	input  wire logic         i_re,
	input  wire logic [9:0]   i_x,
	input  wire logic [8:0]   i_y,
	input  wire logic [W-1:0] i_data,
	output logic      [W-1:0] o_rdata,
	output logic              o_rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [W-1:0] mem [2**19];
	logic [18:0]  ra;
	int           cnt;
	// Between answers the data lines toggle, so a stale value never passes.
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			cnt <= 0;
		end else begin
			o_rvalid <= 1'b0;
			o_rdata <= ~o_rdata;
			if (i_we)
				mem[{i_y, i_x}] <= i_data;
			if (i_re) begin
				ra <= {i_y, i_x};
				cnt <= LAT;
			end else if (cnt > 0) begin
				cnt <= cnt - 1;
				if (cnt == 1) begin
					o_rvalid <= 1'b1;
					o_rdata <= mem[ra];
				end
			end
		end
	end
endmodule : ppw_mem_model

/* test/test_pattern_pixel_writer.sv */
module test_pattern_pixel_writer;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_mclk = 1'b0;
	logic        i_rst = 1'b1;
	logic [15:0] i_addr = 16'h0000;
	logic [7:0]  i_wdata = 8'h00;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [3:0]  i_irq_en = 4'h0;
	logic [7:0]  o_rdata;
	logic        o_mem_we, o_mem_re, o_dma_start, rvalid;
	logic [9:0]  o_mem_x;
	logic [8:0]  o_mem_y;
	logic [11:0] o_mem_data, o_mem_planes, rdata;
	logic [3:0]  o_host_irq;
	logic [1:0]  o_dma_kind, dkind;
	logic [30:0] pix[$], ex[$];
	int          dcnt = 0;
	int          mismatches = 0;
	int          compares = 0;
	localparam logic [7:0] RB = 8'hA5;
	localparam logic [15:0] RA[12] = '{16'h8000, 16'h8002, 16'h8003,
		16'h8004, 16'h8005, 16'h8006, 16'h800C, 16'h800D, 16'h800E,
		16'h800F, 16'h80C4, 16'h9004};
	localparam logic [7:0] RE[12] = '{8'h00, 8'hFF, 8'h0F, 8'hFF, 8'h0F,
		8'h00, 8'h7F, 8'h02, 8'hFF, 8'h01, 8'h00, 8'h00};

	always #2.5 i_mclk = ~i_mclk;

	ppw_pattern_writer #(.PIX_W(12)) DUT (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mem_we(o_mem_we),
		.o_mem_re(o_mem_re), .o_mem_x(o_mem_x), .o_mem_y(o_mem_y),
		.o_mem_data(o_mem_data), .o_mem_planes(o_mem_planes),
		.i_mem_rdata(rdata), .i_mem_rvalid(rvalid), .i_irq_en(i_irq_en),
		.o_host_irq(o_host_irq), .o_dma_start(o_dma_start),
		.o_dma_kind(o_dma_kind));
	ppw_mem_model #(.W(12), .LAT(3)) u_mem (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_we(o_mem_we), .i_re(o_mem_re),
		.i_x(o_mem_x), .i_y(o_mem_y), .i_data(o_mem_data),
		.o_rdata(rdata), .o_rvalid(rvalid));

	always @(posedge i_mclk) begin
		if (o_mem_we === 1'b1)
			pix.push_back({o_mem_x, o_mem_y, o_mem_data});
		if (o_dma_start === 1'b1) begin
			dkind <= o_dma_kind;
			dcnt <= dcnt + 1;
		end
	end
////////////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask : chk

	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask : wr

	task ww(input logic [4:0] r, input logic [15:0] v);
		wr({10'h200, r, 1'b0}, v[7:0]);
		wr({10'h200, r, 1'b1}, v[15:8]);
	endtask : ww

	task rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask : rd

	task idle;
		logic [7:0] s;
		repeat (3) @(posedge i_mclk);
		for (int n = 0; n < 200; n++) begin
			rd(16'h8024, s);
			if (s[7] === 1'b0)
				return;
		end
		chk("busy", 32'(s[7]), 32'h0);
	endtask : idle

	function logic [30:0] pk(input int x, input int y, input logic [11:0] d);
		return {x[9:0], y[8:0], d};
	endfunction : pk

	// Expected pixels are compared in order, so a wrong scan order shows.
	task cmp(input string n);
		chk({n, " count"}, pix.size(), ex.size());
		foreach (ex[i])
			if (i < pix.size())
				chk(n, pix[i], ex[i]);
		pix.delete();
		ex.delete();
	endtask : cmp

	task report_and_stop;
		if (mismatches == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] b, h;
		logic       t;
		repeat (12) @(posedge i_mclk);
		i_rst <= 1'b0;
		for (int i = 0; i < 12; i++) begin
			rd(RA[i], b);
			chk("register", b, RE[i]);
		end
		chk("planes", o_mem_planes, 12'hFFF);
		ww(5'h02, 16'h0111);
		ww(5'h03, 16'h0222);
		ww(5'h04, 16'h000A);
		ww(5'h05, 16'h0014);
		ww(5'h06, 16'h000D);
		ww(5'h07, 16'h001E);
		for (int m = 0; m < 4; m++) begin
			ww(5'h00, m == 3 ? 16'h0010 : 16'(m));
			ww(5'h08, 16'h000A);
			ww(5'h09, 16'h0014);
			ww(5'h0B, 16'(RB));
			idle();
			for (int i = 0; i < 8; i++) begin
				t = RB[7 - i];
				if (m != 2 || t)
					ex.push_back(pk(m == 3 ? 10 : 10 + i % 4,
						m == 3 ? 20 + i : 20 + i / 4,
						(t ^ (m == 1)) ? 12'h111 : 12'h222));
			end
			cmp("raster");
		end
		ww(5'h00, 16'h0000);
		ww(5'h13, 16'h0108);
		ww(5'h14, 16'h0010);
		ww(5'h13, 16'h0008);
		ww(5'h14, 16'h0010);
		ww(5'h08, 16'h000A);
		ww(5'h09, 16'h0014);
		ww(5'h0A, 16'h6041);
		idle();
		for (int r = 0; r < 9; r++)
			for (int c = 0; c < 4; c++)
				ex.push_back(pk(10 + c, 20 + r,
					(r == 1 && c == 1) ? 12'h111 : 12'h222));
		cmp("text");
		ww(5'h0D, 16'h0003);
		ww(5'h0E, 16'h0000);
		idle();
		ww(5'h0E, 16'h0002);
		idle();
		for (int i = 0; i < 4; i++)
			ex.push_back(pk(i, 0, 12'h111));
		for (int i = 0; i < 3; i++)
			ex.push_back(pk(3, i, 12'h111));
		cmp("line");
		ww(5'h0D, 16'h0001);
		ww(5'h0F, 16'h0001);
		idle();
		for (int i = 0; i < 4; i++)
			ex.push_back(pk(i % 2, i / 2, 12'h111));
		cmp("bar");
		ww(5'h04, 16'h0000);
		ww(5'h05, 16'h0000);
		ww(5'h06, 16'h027F);
		ww(5'h07, 16'h01FF);
		ww(5'h08, 16'h0141);
		ww(5'h09, 16'h0105);
		ww(5'h0C, 16'hFABC);
		idle();
		ex.push_back(pk(319, 5, 12'hABC));
		cmp("image");
		ww(5'h08, 16'h0141);
		ww(5'h09, 16'h0105);
		ww(5'h10, 16'h0000);
		idle();
		rd(16'h8024, b);
		chk("read ready", b[6], 1'b1);
		rd(16'h8022, b);
		rd(16'h8023, h);
		chk("readback", {h, b}, 16'h0ABC);
		ww(5'h00, 16'h000C);
		ww(5'h08, 16'h0141);
		ww(5'h09, 16'h0105);
		ww(5'h0C, 16'h0123);
		idle();
		ex.push_back(pk(321, 261, 12'h123));
		cmp("wide image");
		ww(5'h15, 16'h000F);
		repeat (8) @(posedge i_mclk);
		i_irq_en <= 4'h5;
		#1 chk("irq off", o_host_irq, 4'h0);
		repeat (8) @(posedge i_mclk);
		#1 chk("irq on", o_host_irq, 4'h5);
		ww(5'h15, 16'h00F0);
		repeat (3) @(posedge i_mclk);
		#1 chk("irq clear", o_host_irq, 4'h0);
		for (int k = 0; k < 4; k++) begin
			ww(5'h16, 16'(k));
			repeat (2) @(posedge i_mclk);
			chk("dma count", dcnt, k + 1);
			chk("dma kind", dkind, k);
		end
		wr(16'h7F04, 8'h00);
		wr(16'h7F05, 8'h00);
		rd(16'h8004, b);
		chk("decode", b, 8'h11);
		report_and_stop();
	end

	initial begin
		repeat (30000) @(posedge i_mclk);
		mismatches++;
		report_and_stop();
	end
endmodule : test_pattern_pixel_writer
